// ===== rtl/cpuad_cfg.svh
`ifndef CPUAD_CFG_SVH
`define CPUAD_CFG_SVH

// Flag positions
`define CPUAD_V_BIT 7
`define CPUAD_H_BIT 4
`define CPUAD_I_BIT 3
`define CPUAD_N_BIT 2
`define CPUAD_Z_BIT 1
`define CPUAD_C_BIT 0
`define CPUAD_FLAGS_MASK 8'h9f
`define CPUAD_FLAGS_RST 8'h08

// Register byte offsets
`define CPUAD_OFS_FLAGS 8'h00
`define CPUAD_OFS_ACC 8'h04
`define CPUAD_OFS_INDEX 8'h08
`define CPUAD_OFS_STACK 8'h0c
`define CPUAD_OFS_PC 8'h10
`define CPUAD_OFS_CTRL 8'h14
`define CPUAD_OFS_STATUS 8'h18

// Reset values
`define CPUAD_ACC_RST 8'h00
`define CPUAD_INDEX_RST 16'h0000
`define CPUAD_STACK_RST 16'h00ff
`define CPUAD_PC_RST 16'h0000

// Opcodes
`define CPUAD_OP_PREFIX 8'h9e
`define CPUAD_OP_STACK_ADJ 8'ha7
`define CPUAD_OP_INDEX_ADJ 8'haf
`define CPUAD_OP_BR_CC 8'h24
`define CPUAD_OP_CMPBR_IX1P 8'h61
`define CPUAD_OP_CMPBR_IXP 8'h71
`define CPUAD_OP_MOVE_IXPD 8'h7e
`define CPUAD_OP_LOAD_INDEX 8'h45
`define CPUAD_LO_ADC 4'h9
`define CPUAD_LO_ADD 4'hb

`endif

// ===== rtl/cpuad_decode.sv
`timescale 1ns/10ps
`default_nettype none
`include "cpuad_cfg.svh"
module cpuad_decode (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Memory bus, read data arrives in the same cycle
    output logic [15:0] bus_addr,
    output logic bus_rd,
    output logic bus_wr,
    output logic [7:0] bus_wdata,
    input wire logic [7:0] bus_rdata
);
    cpuad_pkg::cpuad_state_s r;
    cpuad_pkg::cpuad_state_s next_r;
    cpuad_pkg::cpuad_dec_s dec;
    logic apb_wr;
    logic mapped;
    logic [15:0] ea;
    logic [15:0] target;
    logic [7:0] sum;
    logic [7:0] flags;
    logic [15:0] rd_sext;
    logic [15:0] word;

    // ****************************************
    // Opcode decode
    // ****************************************
    function automatic cpuad_pkg::cpuad_dec_s decode(input logic pre,
                                                     input logic [7:0] opc);
        cpuad_pkg::cpuad_dec_s d;
        d.cls = cpuad_pkg::C_ILL;
        d.mode = cpuad_pkg::M_NONE;
        if (opc[3:0] == `CPUAD_LO_ADC || opc[3:0] == `CPUAD_LO_ADD)
        begin
            if (pre && opc[7:4] == 4'hd)
                d.mode = cpuad_pkg::M_SP2;
            else if (pre && opc[7:4] == 4'he)
                d.mode = cpuad_pkg::M_SP1;
            else if (!pre)
            begin
                unique case (opc[7:4])
                    4'ha: d.mode = cpuad_pkg::M_IMM8;
                    4'hb: d.mode = cpuad_pkg::M_DIR;
                    4'hc: d.mode = cpuad_pkg::M_EXT;
                    4'hd: d.mode = cpuad_pkg::M_IX2;
                    4'he: d.mode = cpuad_pkg::M_IX1;
                    4'hf: d.mode = cpuad_pkg::M_IX;
                    default: d.mode = cpuad_pkg::M_NONE;
                endcase
            end
            if (d.mode != cpuad_pkg::M_NONE)
                d.cls = (opc[3:0] == `CPUAD_LO_ADC) ? cpuad_pkg::C_ADC
                                                    : cpuad_pkg::C_ADD;
        end
        else if (!pre)
        begin
            unique case (opc)
                `CPUAD_OP_STACK_ADJ:
                begin
                    d.cls = cpuad_pkg::C_AIS;
                    d.mode = cpuad_pkg::M_IMM8;
                end
                `CPUAD_OP_INDEX_ADJ:
                begin
                    d.cls = cpuad_pkg::C_AIX;
                    d.mode = cpuad_pkg::M_IMM8;
                end
                `CPUAD_OP_BR_CC:
                begin
                    d.cls = cpuad_pkg::C_BCC;
                    d.mode = cpuad_pkg::M_REL;
                end
                `CPUAD_OP_CMPBR_IX1P:
                begin
                    d.cls = cpuad_pkg::C_COMPARE_BRANCH_EQUAL;
                    d.mode = cpuad_pkg::M_IX1P;
                end
                `CPUAD_OP_CMPBR_IXP:
                begin
                    d.cls = cpuad_pkg::C_COMPARE_BRANCH_EQUAL;
                    d.mode = cpuad_pkg::M_IXP;
                end
                `CPUAD_OP_MOVE_IXPD:
                begin
                    d.cls = cpuad_pkg::C_MOV;
                    d.mode = cpuad_pkg::M_IXP;
                end
                `CPUAD_OP_LOAD_INDEX:
                begin
                    d.cls = cpuad_pkg::C_LDHX;
                    d.mode = cpuad_pkg::M_IMM16;
                end
                default: d.cls = cpuad_pkg::C_ILL;
            endcase
        end
        return d;
    endfunction

    assign dec = decode(r.st == cpuad_pkg::ST_PRE, bus_rdata);
    assign rd_sext = {{8{bus_rdata[7]}}, bus_rdata};
    assign word = {r.hi, bus_rdata};

    cpuad_ea_alu u_ea_alu (
        .mode(r.mode),
        .hx(r.hx),
        .sp(r.sp),
        .pc(r.pc),
        .hi(r.hi),
        .byte_in(bus_rdata),
        .acc(r.a),
        .carry_in(r.condition_flags[`CPUAD_C_BIT]),
        .use_carry(r.cls == cpuad_pkg::C_ADC),
        .ea(ea),
        .target(target),
        .sum(sum),
        .flags(flags)
    );

    // ****************************************
    // APB slave
    // ****************************************
    assign apb_wr = psel & penable & pwrite;
    assign pready = 1'b1;
    assign mapped = (paddr == `CPUAD_OFS_FLAGS) || (paddr == `CPUAD_OFS_ACC)
        || (paddr == `CPUAD_OFS_INDEX) || (paddr == `CPUAD_OFS_STACK)
        || (paddr == `CPUAD_OFS_PC) || (paddr == `CPUAD_OFS_CTRL)
        || (paddr == `CPUAD_OFS_STATUS);
    assign pslverr = psel & penable & ~mapped;

    always_comb
    begin
        prdata = 32'h0000_0000;
        unique case (paddr)
            `CPUAD_OFS_FLAGS: prdata[7:0] = r.condition_flags;
            `CPUAD_OFS_ACC: prdata[7:0] = r.a;
            `CPUAD_OFS_INDEX: prdata[15:0] = r.hx;
            `CPUAD_OFS_STACK: prdata[15:0] = r.sp;
            `CPUAD_OFS_PC: prdata[15:0] = r.pc;
            `CPUAD_OFS_CTRL: prdata[0] = r.run;
            `CPUAD_OFS_STATUS: prdata = {r.ea, r.op, 4'h0, r.illegal, r.st};
            default: prdata = 32'h0000_0000;
        endcase
    end

    // ****************************************
    // Sequencer
    // ****************************************
    always_comb
    begin
        next_r = r;
        // Core registers are writable only while stopped, so software
        // never races an instruction in flight
        if (apb_wr && !r.run)
        begin
            unique case (paddr)
                `CPUAD_OFS_FLAGS: next_r.condition_flags = pwdata[7:0] & `CPUAD_FLAGS_MASK;
                `CPUAD_OFS_ACC: next_r.a = pwdata[7:0];
                `CPUAD_OFS_INDEX: next_r.hx = pwdata[15:0];
                `CPUAD_OFS_STACK: next_r.sp = pwdata[15:0];
                `CPUAD_OFS_PC: next_r.pc = pwdata[15:0];
                default: next_r.a = r.a;
            endcase
        end
        if (apb_wr && paddr == `CPUAD_OFS_CTRL)
        begin
            next_r.run = pwdata[0];
            if (pwdata[1])
                next_r.illegal = 1'b0;
        end
        if (r.run)
        begin
            unique case (r.st)
                cpuad_pkg::ST_FETCH, cpuad_pkg::ST_PRE:
                begin
                    next_r.pc = r.pc + 16'h0001;
                    next_r.op = bus_rdata;
                    next_r.cls = dec.cls;
                    next_r.mode = dec.mode;
                    if (r.st == cpuad_pkg::ST_FETCH && bus_rdata == `CPUAD_OP_PREFIX)
                        next_r.st = cpuad_pkg::ST_PRE;
                    else if (dec.cls == cpuad_pkg::C_ILL)
                    begin
                        // Hardware set wins over the software clear
                        next_r.illegal = 1'b1;
                        next_r.run = 1'b0;
                        next_r.st = cpuad_pkg::ST_FETCH;
                    end
                    else if (dec.mode == cpuad_pkg::M_IX)
                    begin
                        next_r.ea = r.hx;
                        next_r.st = cpuad_pkg::ST_DATA;
                    end
                    else if (dec.cls == cpuad_pkg::C_COMPARE_BRANCH_EQUAL && dec.mode == cpuad_pkg::M_IXP)
                    begin
                        next_r.ea = r.hx;
                        next_r.st = cpuad_pkg::ST_REL;
                    end
                    else
                        next_r.st = cpuad_pkg::ST_OPHI;
                end
                cpuad_pkg::ST_OPHI:
                begin
                    next_r.pc = r.pc + 16'h0001;
                    next_r.hi = bus_rdata;
                    next_r.st = cpuad_pkg::ST_FETCH;
                    unique case (r.cls)
                        cpuad_pkg::C_AIS: next_r.sp = r.sp + rd_sext;
                        cpuad_pkg::C_AIX: next_r.hx = r.hx + rd_sext;
                        cpuad_pkg::C_BCC: next_r.st = cpuad_pkg::ST_EXEC;
                        cpuad_pkg::C_LDHX: next_r.st = cpuad_pkg::ST_OPLO;
                        cpuad_pkg::C_MOV:
                        begin
                            next_r.dd = bus_rdata;
                            next_r.ea = r.hx;
                            next_r.st = cpuad_pkg::ST_DATA;
                        end
                        cpuad_pkg::C_COMPARE_BRANCH_EQUAL:
                        begin
                            next_r.ea = ea;
                            next_r.st = cpuad_pkg::ST_REL;
                        end
                        default:
                        begin
                            if (r.mode == cpuad_pkg::M_IMM8)
                            begin
                                next_r.a = sum;
                                next_r.condition_flags = (r.condition_flags & (8'h01 << `CPUAD_I_BIT))
                                    | flags;
                            end
                            else if (r.mode == cpuad_pkg::M_EXT || r.mode == cpuad_pkg::M_IX2
                                     || r.mode == cpuad_pkg::M_SP2)
                                next_r.st = cpuad_pkg::ST_OPLO;
                            else
                            begin
                                next_r.ea = ea;
                                next_r.st = cpuad_pkg::ST_DATA;
                            end
                        end
                    endcase
                end
                cpuad_pkg::ST_OPLO:
                begin
                    next_r.pc = r.pc + 16'h0001;
                    if (r.cls == cpuad_pkg::C_LDHX)
                    begin
                        next_r.hx = word;
                        next_r.condition_flags[`CPUAD_V_BIT] = 1'b0;
                        next_r.condition_flags[`CPUAD_N_BIT] = word[15];
                        next_r.condition_flags[`CPUAD_Z_BIT] = (word == 16'h0000);
                        next_r.st = cpuad_pkg::ST_FETCH;
                    end
                    else
                    begin
                        next_r.ea = ea;
                        next_r.st = cpuad_pkg::ST_DATA;
                    end
                end
                cpuad_pkg::ST_REL:
                begin
                    next_r.pc = r.pc + 16'h0001;
                    next_r.hi = bus_rdata;
                    next_r.st = cpuad_pkg::ST_DATA;
                end
                cpuad_pkg::ST_DATA:
                begin
                    next_r.st = cpuad_pkg::ST_FETCH;
                    unique case (r.cls)
                        cpuad_pkg::C_COMPARE_BRANCH_EQUAL:
                        begin
                            // Flags stay untouched; index moves on after the read
                            if (bus_rdata == r.a)
                                next_r.pc = target;
                            next_r.hx = r.hx + 16'h0001;
                        end
                        cpuad_pkg::C_MOV:
                        begin
                            next_r.bus_wdata = bus_rdata;
                            next_r.hx = r.hx + 16'h0001;
                            next_r.ea = {8'h00, r.dd};
                            next_r.st = cpuad_pkg::ST_EXEC;
                        end
                        default:
                        begin
                            next_r.a = sum;
                            next_r.condition_flags = (r.condition_flags & (8'h01 << `CPUAD_I_BIT))
                                | flags;
                        end
                    endcase
                end
                cpuad_pkg::ST_EXEC:
                begin
                    next_r.st = cpuad_pkg::ST_FETCH;
                    if (r.cls == cpuad_pkg::C_BCC && !r.condition_flags[`CPUAD_C_BIT])
                        next_r.pc = target;
                end
                default: next_r.st = cpuad_pkg::ST_FETCH;
            endcase
        end
        // Bus request for the cycle the next state stands in
        next_r.bus_rd = next_r.run && next_r.st != cpuad_pkg::ST_EXEC;
        next_r.bus_wr = next_r.run && next_r.st == cpuad_pkg::ST_EXEC
            && next_r.cls == cpuad_pkg::C_MOV;
        next_r.bus_addr = (next_r.st == cpuad_pkg::ST_DATA
                           || next_r.st == cpuad_pkg::ST_EXEC) ? next_r.ea : next_r.pc;
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            r <= '0;
            r.st <= cpuad_pkg::ST_FETCH;
            r.a <= `CPUAD_ACC_RST;
            r.hx <= `CPUAD_INDEX_RST;
            r.sp <= `CPUAD_STACK_RST;
            r.pc <= `CPUAD_PC_RST;
            r.bus_addr <= `CPUAD_PC_RST;
            r.condition_flags <= `CPUAD_FLAGS_RST;
        end
        else
            r <= next_r;
    end

    assign bus_addr = r.bus_addr;
    assign bus_rd = r.bus_rd;
    assign bus_wr = r.bus_wr;
    assign bus_wdata = r.bus_wdata;

    // ****************************************
    // Checks
    // ****************************************
    logic [8:0] chk_sum;
    logic [15:0] chk_ix1;
    assign chk_sum = {1'b0, r.a} + {1'b0, bus_rdata};
    assign chk_ix1 = r.hx + {8'h00, bus_rdata};

    add_carry_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (r.run && r.st == cpuad_pkg::ST_DATA && r.cls == cpuad_pkg::C_ADD)
        |=> r.condition_flags[`CPUAD_C_BIT] == $past(chk_sum[8]) && r.a == $past(chk_sum[7:0]))
        else $error("carry not taken from bit 7");
    mask_kept_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (r.run && r.st == cpuad_pkg::ST_DATA && r.cls == cpuad_pkg::C_ADC)
        |=> $stable(r.condition_flags[`CPUAD_I_BIT]))
        else $error("add changed interrupt mask");
    direct_page_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (r.run && r.st == cpuad_pkg::ST_OPHI && r.mode == cpuad_pkg::M_DIR)
        |=> r.ea == {8'h00, $past(bus_rdata)} && bus_addr == r.ea)
        else $error("direct page address wrong");
    imm_word_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (r.run && r.st == cpuad_pkg::ST_OPLO && r.cls == cpuad_pkg::C_LDHX)
        |=> r.hx == {$past(r.hi), $past(bus_rdata)})
        else $error("immediate word byte order wrong");
    ext_addr_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (r.run && r.st == cpuad_pkg::ST_OPLO && r.mode == cpuad_pkg::M_EXT)
        |=> bus_rd && bus_addr == {$past(r.hi), $past(bus_rdata)})
        else $error("extended address wrong");
    adjust_cycles_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (r.run && r.st == cpuad_pkg::ST_FETCH && bus_rdata == `CPUAD_OP_STACK_ADJ)
        |=> r.st == cpuad_pkg::ST_OPHI ##1 (r.st == cpuad_pkg::ST_FETCH
        && r.condition_flags == $past(r.condition_flags, 2)))
        else $error("stack adjust timing or flags wrong");
    carry_branch_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (r.run && r.st == cpuad_pkg::ST_FETCH && bus_rdata == `CPUAD_OP_BR_CC)
        |=> r.st == cpuad_pkg::ST_OPHI ##1 r.st == cpuad_pkg::ST_EXEC
        ##1 r.st == cpuad_pkg::ST_FETCH)
        else $error("carry-clear branch not three cycles");
    branch_target_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (r.run && r.st == cpuad_pkg::ST_EXEC && r.cls == cpuad_pkg::C_BCC)
        |=> r.pc == ($past(r.condition_flags[`CPUAD_C_BIT]) ? $past(r.pc) : $past(target)))
        else $error("branch target wrong");
    index_offset_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (r.run && r.st == cpuad_pkg::ST_OPHI && r.mode == cpuad_pkg::M_IX1)
        |=> r.ea == $past(chk_ix1))
        else $error("indexed offset not zero-extended");
    post_inc_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (r.run && r.st == cpuad_pkg::ST_DATA && r.cls == cpuad_pkg::C_COMPARE_BRANCH_EQUAL)
        |=> r.hx == $past(r.hx) + 16'h0001)
        else $error("index not post-incremented");
endmodule
`default_nettype wire

// ===== rtl/cpuad_ea_alu.sv
`timescale 1ns/10ps
`default_nettype none
`include "cpuad_cfg.svh"
module cpuad_ea_alu (
    // Addressing inputs
    input wire cpuad_pkg::cpuad_mode_e mode,
    input wire logic [15:0] hx,
    input wire logic [15:0] sp,
    input wire logic [15:0] pc,
    input wire logic [7:0] hi,
    input wire logic [7:0] byte_in,
    // Arithmetic inputs
    input wire logic [7:0] acc,
    input wire logic carry_in,
    input wire logic use_carry,
    // Results
    output logic [15:0] ea,
    output logic [15:0] target,
    output logic [7:0] sum,
    output logic [7:0] flags
);
    logic [15:0] off8;
    logic [15:0] word;
    logic [8:0] full;
    logic [4:0] half;
    logic cin;

    assign off8 = {8'h00, byte_in};
    assign word = {hi, byte_in};
    assign target = pc + {{8{hi[7]}}, hi};
    assign cin = use_carry & carry_in;
    assign full = {1'b0, acc} + {1'b0, byte_in} + {8'h00, cin};
    assign half = {1'b0, acc[3:0]} + {1'b0, byte_in[3:0]} + {4'h0, cin};
    assign sum = full[7:0];

    always_comb
    begin
        flags = 8'h00;
        flags[`CPUAD_V_BIT] = (acc[7] & byte_in[7] & ~sum[7])
            | (~acc[7] & ~byte_in[7] & sum[7]);
        flags[`CPUAD_H_BIT] = half[4];
        flags[`CPUAD_N_BIT] = sum[7];
        flags[`CPUAD_Z_BIT] = (sum == 8'h00);
        flags[`CPUAD_C_BIT] = full[8];
    end

    always_comb
    begin
        unique case (mode)
            cpuad_pkg::M_DIR: ea = off8;
            cpuad_pkg::M_EXT: ea = word;
            cpuad_pkg::M_IX1, cpuad_pkg::M_IX1P: ea = hx + off8;
            cpuad_pkg::M_IX2: ea = hx + word;
            cpuad_pkg::M_SP1: ea = sp + off8;
            cpuad_pkg::M_SP2: ea = sp + word;
            default: ea = hx;
        endcase
    end
endmodule
`default_nettype wire

// ===== rtl/cpuad_pkg.sv
package cpuad_pkg;

    typedef enum logic [2:0] {
        ST_FETCH = 3'h0,
        ST_OPHI = 3'h1,
        ST_OPLO = 3'h3,
        ST_DATA = 3'h2,
        ST_EXEC = 3'h6,
        ST_REL = 3'h7,
        ST_PRE = 3'h4
    } cpuad_state_e;

    typedef enum logic [3:0] {
        M_NONE, M_IMM8, M_IMM16, M_DIR, M_EXT, M_IX, M_IX1, M_IX2,
        M_SP1, M_SP2, M_IXP, M_IX1P, M_REL
    } cpuad_mode_e;

    typedef enum logic [3:0] {
        C_ILL, C_ADC, C_ADD, C_AIS, C_AIX, C_BCC, C_COMPARE_BRANCH_EQUAL, C_MOV, C_LDHX
    } cpuad_cls_e;

    typedef struct packed {
        cpuad_cls_e cls;
        cpuad_mode_e mode;
    } cpuad_dec_s;

    typedef struct packed {
        cpuad_state_e st;
        logic run;
        logic illegal;
        logic [7:0] a;
        logic [15:0] hx;
        logic [15:0] sp;
        logic [15:0] pc;
        logic [7:0] condition_flags;
        logic [7:0] op;
        logic [7:0] hi;
        logic [7:0] dd;
        cpuad_cls_e cls;
        cpuad_mode_e mode;
        logic [15:0] ea;
        logic [15:0] bus_addr;
        logic bus_rd;
        logic bus_wr;
        logic [7:0] bus_wdata;
    } cpuad_state_s;

endpackage

// ===== testbench/cpu_operand_addressing_decode_bench.sv
`timescale 1ns/10ps
`default_nettype none
module cpu_operand_addressing_decode_bench;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, r;
    logic pready, pslverr, bus_rd, bus_wr, e;
    logic [15:0] bus_addr;
    logic [7:0] bus_wdata, bus_rdata;
    int miscompares = 0;
    int n_checks = 0;
    int cyc = 0;
    always #20 clk_sys = ~clk_sys;
    cpuad_decode cpuad_decode_i (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus_addr(bus_addr),
        .bus_rd(bus_rd), .bus_wr(bus_wr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata));
    cpuad_mem cpuad_mem_i (.clk_sys(clk_sys), .bus_addr(bus_addr), .bus_rd(bus_rd),
        .bus_wr(bus_wr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata));
    // ****************
    // Bench tasks
    // ****************
    task give_verdict;
        if (miscompares == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Request held until pready is seen high at a rising edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task ld(input logic [15:0] a, input logic [63:0] v, input int n);
        for (int i = 0; i < n; i++)
            cpuad_mem_i.mem[a + i] = v[8 * (n - 1 - i) +: 8];
    endtask
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            miscompares++;
            give_verdict;
        end
    end
    // ****************
    // Program run
    // ****************
    initial
    begin
        // add #1, stack -1, carry-clear branch, then ext, imm16, ix1, ix2 and dir operand modes and index -2
        ld(16'h0100, 64'hab01a7ff2410, 6);
        ld(16'h0116, 64'hc9123445ff80e990, 8);
        ld(16'h011e, 64'hd98000bb40affe, 7);
        // Compare-branch through the index pair, operand differs so no branch
        ld(16'h0125, 64'h7102, 2);
        cpuad_mem_i.mem[16'h1234] = 8'h80;
        cpuad_mem_i.mem[16'h0010] = 8'h01;
        cpuad_mem_i.mem[16'h7f80] = 8'h0f;
        cpuad_mem_i.mem[16'h0040] = 8'hf0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        apb(1'b0, 8'h00, 32'h0);
        chk(r, 32'h08);
        apb(1'b0, 8'h0c, 32'h0);
        chk(r, 32'hff);
        apb(1'b0, 8'h1c, 32'h0);
        chk({r[30:0], e}, 32'h1);
        apb(1'b1, 8'h10, 32'h100);
        apb(1'b1, 8'h04, 32'h7f);
        apb(1'b1, 8'h14, 32'h1);
        repeat (200)
        begin
            apb(1'b0, 8'h14, 32'h0);
            if (r[0] === 1'b0)
                break;
        end
        apb(1'b0, 8'h04, 32'h0);
        chk(r, 32'h01);
        apb(1'b0, 8'h00, 32'h0);
        chk(r, 32'h09);
        apb(1'b0, 8'h08, 32'h0);
        chk(r, 32'hff7f);
        apb(1'b0, 8'h10, 32'h0);
        chk(r, 32'h0128);
        apb(1'b0, 8'h0c, 32'h0);
        chk(r, 32'hfe);
        apb(1'b0, 8'h18, 32'h0);
        chk(r & 32'hffff, 32'h0008);
        chk(cpuad_mem_i.hit[16'h0116], 32'h1);
        chk(cpuad_mem_i.hit[16'h0106], 32'h0);
        chk(cpuad_mem_i.hit[16'h1234], 32'h1);
        chk(cpuad_mem_i.hit[16'h0010], 32'h1);
        chk(cpuad_mem_i.hit[16'hff10], 32'h0);
        chk(cpuad_mem_i.hit[16'h7f80], 32'h1);
        chk(cpuad_mem_i.hit[16'h0040], 32'h1);
        chk(cpuad_mem_i.hit[16'hff7e], 32'h1);
        give_verdict;
    end
endmodule
`default_nettype wire

// ===== testbench/cpuad_mem.sv
`timescale 1ns/10ps
`default_nettype none
module cpuad_mem (
    // Clock
    input wire logic clk_sys,
    // Memory bus from the core
    input wire logic [15:0] bus_addr,
    input wire logic bus_rd,
    input wire logic bus_wr,
    input wire logic [7:0] bus_wdata,
    output logic [7:0] bus_rdata
);
    bit [7:0] mem [0:65535];
    bit hit [0:65535];
    // Not selected: inverse data, so a stray sample never matches by luck
    assign bus_rdata = bus_rd ? mem[bus_addr] : ~mem[bus_addr];
    // Reads are logged so the bench can see every effective address read; writes are not logged
    always @(posedge clk_sys)
    begin
        if (bus_rd)
            hit[bus_addr] <= 1'b1;
        if (bus_wr)
            mem[bus_addr] <= bus_wdata;
    end
endmodule
`default_nettype wire
